// File: core/src_defs.vh
// constants for the system reset controller: offsets, fields, reset values, timing
`ifndef SRC_DEFS_VH
`define SRC_DEFS_VH

// register byte offsets (word aligned)
`define SRC_OFF_RESET_CAUSE 8'h00
`define SRC_OFF_CLK_STATUS 8'h04
`define SRC_OFF_FLASH_CTRL 8'h08
`define SRC_OFF_RTC_CALIB 8'h0C

// reset_cause_control fields
`define SRC_B_TRAP 15
`define SRC_B_ILLOP 14
`define SRC_B_SW_BROWNOUT_ENABLE 13
`define SRC_B_CFGMIS 9
`define SRC_B_FLASH_POWER_IN_SLEEP 8
`define SRC_B_PIN 7
`define SRC_B_INSTR 6
`define SRC_B_SW_WATCHDOG_ENABLE 5
`define SRC_B_WATCHDOG_TIMEOUT_FLAG 4
`define SRC_B_SLEEP 3
`define SRC_B_IDLE 2
`define SRC_B_BOR 1
`define SRC_B_POR 0
`define SRC_RESET_CAUSE_CONTROL_IMPL_MASK 16'hE3FF
`define SRC_RESET_CAUSE_CONTROL_POR_VAL 16'h0003

// brown-out configuration codes
`define SRC_BOR_OFF 2'h0
`define SRC_BOR_SW 2'h1
`define SRC_BOR_NOSLEEP 2'h2
`define SRC_BOR_ON 2'h3

// oscillator selection codes
`define SRC_OSC_FRC 3'h0
`define SRC_OSC_FRCPLL 3'h1
`define SRC_OSC_PRI 3'h2
`define SRC_OSC_PRIPLL 3'h3
`define SRC_OSC_SOSC 3'h4
`define SRC_OSC_LPRC 3'h5
`define SRC_OSC_FRCDIV 3'h7

// timing
`define SRC_CLK_KHZ 100000
`define SRC_POWERUP_TIMER_MS 64
`define SRC_POWERON_DELAY_US 2
`define SRC_OST_PERIODS 1024
`define SRC_OST_W 10

`endif

// File: core/src_reset_ctrl.v
// system reset controller: reset combining, cause register, release timing, clock source selection
//
// The register offsets and register access over Wishbone were decided locally.
`include "src_defs.vh"
`default_nettype none

module src_reset_ctrl #(
	parameter [31:0] POWERUP_DELAY_CYC = `SRC_POWERUP_TIMER_MS * `SRC_CLK_KHZ
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// reset sources
	input wire por_i,
	input wire master_clear_pin_i,
	input wire reset_instr_i,
	input wire watchdog_timeout_i,
	input wire brownout_i,
	input wire trap_conflict_i,
	input wire illegal_op_i,
	input wire config_mismatch_i,
	// power-save instructions and state
	input wire sleep_instr_i,
	input wire idle_instr_i,
	input wire in_sleep_i,
	// configuration word
	input wire [1:0] brownout_config_i,
	input wire watchdog_fuse_i,
	input wire [2:0] config_osc_select_i,
	input wire clk_switch_en_i,
	input wire powerup_timer_en_i,
	input wire two_speed_en_i,
	input wire clock_fail_monitor_en_i,
	input wire primary_is_crystal_i,
	// oscillator block
	input wire osc_tick_i,
	input wire pll_lock_i,
	input wire clock_valid_i,
	input wire [2:0] current_osc_select_i,
	// outputs
	output wire master_system_reset_o,
	output wire code_run_o,
	output wire [2:0] osc_select_o,
	output wire clock_fail_monitor_run_o,
	output wire flash_power_in_sleep_o,
	output wire watchdog_enable_o,
	output wire brownout_enable_o
);

	localparam [31:0] POWERON_DELAY_CYC = `SRC_POWERON_DELAY_US * (`SRC_CLK_KHZ / 1000);
	localparam [31:0] OST_COUNT_LAST = `SRC_OST_PERIODS - 1;
	localparam [`SRC_OST_W-1:0] OST_LAST = OST_COUNT_LAST[`SRC_OST_W-1:0];

	// release sequencer states
	localparam [2:0] ST_HOLD = 3'h1;
	localparam [2:0] ST_DELAY = 3'h2;
	localparam [2:0] ST_RUN = 3'h4;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wdat;
		input [3:0] sel;
		begin
			merge16 = old;
			if (sel[0]) merge16[7:0] = wdat[7:0];
			if (sel[1]) merge16[15:8] = wdat[15:8];
		end
	endfunction

	function needs_pll;
		input [2:0] sel;
		begin
			needs_pll = (sel == `SRC_OSC_FRCPLL) || (sel == `SRC_OSC_PRIPLL);
		end
	endfunction

	function needs_ost;
		input [2:0] sel;
		input crystal;
		begin
			needs_ost = (sel == `SRC_OSC_SOSC) ||
				(crystal && ((sel == `SRC_OSC_PRI) || (sel == `SRC_OSC_PRIPLL)));
		end
	endfunction

	reg [15:0] reset_cause_control_reg, reset_cause_control_next;
	reg [15:0] flash_ctrl_reg, rtc_calib_reg;
	reg [2:0] state_reg, state_next;
	reg [31:0] delay_reg, delay_next;
	reg por_kind_reg, bor_kind_reg;
	reg msr_reg;
	reg [`SRC_OST_W-1:0] ost_reg;
	reg clk_rel_reg;
	reg [2:0] osc_sel_reg;
	reg clock_fail_monitor_run_reg, fail_sw_reg;
	reg ack_reg;
	reg [31:0] dat_reg;
	reg code_run_reg, wdt_en_reg, bor_en_reg;

	wire por_evt = rst_i | por_i;
	wire sbor_allowed = (brownout_config_i == `SRC_BOR_SW);
	reg bor_active;
	always @* begin
		case (brownout_config_i)
			`SRC_BOR_SW: bor_active = reset_cause_control_reg[`SRC_B_SW_BROWNOUT_ENABLE];
			`SRC_BOR_NOSLEEP: bor_active = ~in_sleep_i;
			`SRC_BOR_ON: bor_active = 1'b1;
			default: bor_active = 1'b0;
		endcase
	end
	wire bor_evt = brownout_i & bor_active;
	wire any_src = por_evt | master_clear_pin_i | reset_instr_i | watchdog_timeout_i |
		bor_evt | trap_conflict_i | illegal_op_i | config_mismatch_i;

	// bus access
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire bus_wr = bus_req & wb_we_i;
	wire wr_reset_cause_control = bus_wr && (wb_adr_i == `SRC_OFF_RESET_CAUSE);
	wire wr_flash = bus_wr && (wb_adr_i == `SRC_OFF_FLASH_CTRL);
	wire wr_calib = bus_wr && (wb_adr_i == `SRC_OFF_RTC_CALIB);

	wire [15:0] clk_status = {8'h00, msr_reg, code_run_reg, clk_rel_reg, clock_fail_monitor_run_reg,
		fail_sw_reg, osc_sel_reg};

	// cause register: software write first, hardware sets win over it
	always @* begin
		reset_cause_control_next = reset_cause_control_reg;
		if (wr_reset_cause_control)
			reset_cause_control_next = merge16(reset_cause_control_reg, wb_dat_i, wb_sel_i);
		if (sleep_instr_i | idle_instr_i)
			reset_cause_control_next[`SRC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		if (trap_conflict_i) reset_cause_control_next[`SRC_B_TRAP] = 1'b1;
		if (illegal_op_i) reset_cause_control_next[`SRC_B_ILLOP] = 1'b1;
		if (config_mismatch_i) reset_cause_control_next[`SRC_B_CFGMIS] = 1'b1;
		if (master_clear_pin_i) reset_cause_control_next[`SRC_B_PIN] = 1'b1;
		if (reset_instr_i) reset_cause_control_next[`SRC_B_INSTR] = 1'b1;
		if (watchdog_timeout_i) reset_cause_control_next[`SRC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		if (sleep_instr_i) reset_cause_control_next[`SRC_B_SLEEP] = 1'b1;
		if (idle_instr_i) reset_cause_control_next[`SRC_B_IDLE] = 1'b1;
		if (bor_evt) reset_cause_control_next[`SRC_B_BOR] = 1'b1;
		if (por_evt) begin
			reset_cause_control_next = `SRC_RESET_CAUSE_CONTROL_POR_VAL;
			reset_cause_control_next[`SRC_B_SW_BROWNOUT_ENABLE] = sbor_allowed;
		end
		if (!sbor_allowed)
			reset_cause_control_next[`SRC_B_SW_BROWNOUT_ENABLE] = 1'b0;
		reset_cause_control_next = reset_cause_control_next & `SRC_RESET_CAUSE_CONTROL_IMPL_MASK;
	end

	always @(posedge clk_i) begin
		reset_cause_control_reg <= reset_cause_control_next;
		if (por_evt) begin
			flash_ctrl_reg <= 16'h0000;
			rtc_calib_reg <= 16'h0000;
		end else begin
			if (wr_flash)
				flash_ctrl_reg <= merge16(flash_ctrl_reg, wb_dat_i, wb_sel_i);
			if (wr_calib)
				rtc_calib_reg <= merge16(rtc_calib_reg, wb_dat_i, wb_sel_i);
		end
	end

	// wishbone answer one cycle after request; unmapped reads zero, writes dropped
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			ack_reg <= bus_req;
			if (bus_req) begin
				case (wb_adr_i)
					`SRC_OFF_RESET_CAUSE: dat_reg <= {16'h0000, reset_cause_control_reg};
					`SRC_OFF_CLK_STATUS: dat_reg <= {16'h0000, clk_status};
					`SRC_OFF_FLASH_CTRL: dat_reg <= {16'h0000, flash_ctrl_reg};
					`SRC_OFF_RTC_CALIB: dat_reg <= {16'h0000, rtc_calib_reg};
					default: dat_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// release sequencer
	wire por_k = por_kind_reg | por_evt;
	wire bor_k = bor_kind_reg | bor_evt;
	wire [31:0] powerup_timer_cyc = powerup_timer_en_i ? POWERUP_DELAY_CYC : 32'h00000000;

	always @* begin
		state_next = state_reg;
		delay_next = delay_reg;
		case (state_reg)
			ST_HOLD: begin
				if (!any_src) begin
					if (por_kind_reg)
						delay_next = POWERON_DELAY_CYC + powerup_timer_cyc;
					else if (bor_kind_reg)
						delay_next = powerup_timer_cyc;
					else
						delay_next = 32'h00000000;
					state_next = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (delay_reg == 32'h00000000)
					state_next = ST_RUN;
				else
					delay_next = delay_reg - 32'h00000001;
			end
			ST_RUN: state_next = ST_RUN;
			default: state_next = ST_HOLD;
		endcase
		if (any_src) begin
			state_next = ST_HOLD;
			delay_next = 32'h00000000;
		end
	end

	wire releasing = (state_reg == ST_DELAY) && (state_next == ST_RUN);

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_HOLD;
			delay_reg <= 32'h00000000;
			por_kind_reg <= 1'b1;
			bor_kind_reg <= 1'b0;
			msr_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			delay_reg <= delay_next;
			msr_reg <= (state_next != ST_RUN);
			if (releasing) begin
				por_kind_reg <= 1'b0;
				bor_kind_reg <= 1'b0;
			end else begin
				por_kind_reg <= por_k;
				bor_kind_reg <= bor_k;
			end
		end
	end

	// clock source selection, start-up wait and fail-safe monitor
	reg [2:0] sel_at_reset;
	always @* begin
		if (two_speed_en_i)
			sel_at_reset = `SRC_OSC_FRC;
		else if (!clk_switch_en_i || por_k || bor_k)
			sel_at_reset = config_osc_select_i;
		else
			sel_at_reset = current_osc_select_i;
	end

	wire ost_needed = needs_ost(osc_sel_reg, primary_is_crystal_i);
	wire ost_done = ~ost_needed | (osc_tick_i && (ost_reg == OST_LAST));
	wire lock_ok = ~needs_pll(osc_sel_reg) | pll_lock_i;

	always @(posedge clk_i) begin
		if (rst_i) begin
			// rst_i is a power-on event, so it picks the start-up clock too
			osc_sel_reg <= sel_at_reset;
			ost_reg <= {`SRC_OST_W{1'b0}};
			clk_rel_reg <= 1'b0;
			clock_fail_monitor_run_reg <= 1'b0;
			fail_sw_reg <= 1'b0;
		end else if (any_src) begin
			osc_sel_reg <= sel_at_reset;
			ost_reg <= {`SRC_OST_W{1'b0}};
			clk_rel_reg <= 1'b0;
			clock_fail_monitor_run_reg <= 1'b0;
			fail_sw_reg <= 1'b0;
		end else begin
			// start-up counts while the release delay runs
			if (!clk_rel_reg) begin
				if (ost_needed && osc_tick_i && (ost_reg != OST_LAST))
					ost_reg <= ost_reg + 1'b1;
				if (ost_done && lock_ok)
					clk_rel_reg <= 1'b1;
			end
			if (releasing)
				clock_fail_monitor_run_reg <= clock_fail_monitor_en_i;
			if (((releasing && clock_fail_monitor_en_i) || clock_fail_monitor_run_reg) &&
				!clock_valid_i && (osc_sel_reg != `SRC_OSC_FRC)) begin
				osc_sel_reg <= `SRC_OSC_FRC;
				clk_rel_reg <= 1'b1;
				fail_sw_reg <= 1'b1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			code_run_reg <= 1'b0;
			wdt_en_reg <= 1'b0;
			bor_en_reg <= 1'b0;
		end else begin
			code_run_reg <= ~msr_reg & clk_rel_reg & ~any_src;
			wdt_en_reg <= watchdog_fuse_i | reset_cause_control_reg[`SRC_B_SW_WATCHDOG_ENABLE];
			bor_en_reg <= bor_active;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign master_system_reset_o = msr_reg;
	assign code_run_o = code_run_reg;
	assign osc_select_o = osc_sel_reg;
	assign clock_fail_monitor_run_o = clock_fail_monitor_run_reg;
	assign flash_power_in_sleep_o = reset_cause_control_reg[`SRC_B_FLASH_POWER_IN_SLEEP];
	assign watchdog_enable_o = wdt_en_reg;
	assign brownout_enable_o = bor_en_reg;

endmodule // src_reset_ctrl

`default_nettype wire

// File: dv/src_osc_model.sv
// oscillator block model: period ticks, pll lock, clock presence
`default_nettype none
module src_osc_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_ok_i,
	output logic tick_o,
	output logic lock_o,
	output logic valid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] lock_reg;
	// one tick every second clock, lock some cycles after reset
	always @(posedge clk_i) begin
		tick_o <= !rst_i && !tick_o;
		lock_reg <= rst_i ? 5'h00 : lock_reg + {4'h0, !lock_o};
	end
	assign lock_o = &lock_reg;
	assign valid_o = clk_ok_i;
endmodule // src_osc_model
`default_nettype wire

// File: dv/src_reset_ctrl_asserts.sv
// concurrent checks on the reset controller ports
`default_nettype none
module src_reset_ctrl_asserts (
	input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic por_i, master_clear_pin_i, reset_instr_i, watchdog_timeout_i,
	input wire logic trap_conflict_i, illegal_op_i, config_mismatch_i, brownout_i,
	input wire logic watchdog_fuse_i, clk_switch_en_i, two_speed_en_i,
	input wire logic clock_fail_monitor_en_i, master_system_reset_o, code_run_o,
	input wire logic watchdog_enable_o, flash_power_in_sleep_o,
	input wire logic clock_fail_monitor_run_o,
	input wire logic [2:0] config_osc_select_i, osc_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic src_any = por_i | master_clear_pin_i | reset_instr_i | watchdog_timeout_i
		| trap_conflict_i | illegal_op_i | config_mismatch_i;
	any_source_a: assert property (src_any |=> master_system_reset_o)
		else $error("source without reset");
	run_gate_a: assert property ($rose(code_run_o) |->
		!master_system_reset_o && $past(master_system_reset_o) == 1'b0)
		else $error("run during reset");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_turn_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	sw_write_a: assert property (wb_cyc_i && wb_we_i && !src_any && !brownout_i
		&& !master_system_reset_o |=> !master_system_reset_o)
		else $error("write caused reset");
	flash_bit_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00
		&& wb_sel_i[1] |-> flash_power_in_sleep_o == wb_dat_i[8])
		else $error("flash bit wrong");
	wdt_fuse_a: assert property (watchdog_fuse_i |=> watchdog_enable_o)
		else $error("watchdog off");
	osc_fixed_a: assert property ($fell(master_system_reset_o) && !clk_switch_en_i
		&& !two_speed_en_i |-> osc_select_o == config_osc_select_i)
		else $error("osc not configured");
	mon_start_a: assert property ($fell(master_system_reset_o)
		&& clock_fail_monitor_en_i |-> ##[0:2] clock_fail_monitor_run_o)
		else $error("monitor idle");
endmodule // src_reset_ctrl_asserts
bind src_reset_ctrl src_reset_ctrl_asserts u_chk (.*);
`default_nettype wire

// File: dv/src_reset_ctrl_bench.sv
// self-checking bench for the reset controller over wishbone
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("BAD %0t got %0h want %0h", $time, (a), (b)); end end
module src_reset_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, cyc = 0, we = 0, clk_ok = 1;
	logic [7:0] adr = 8'h00, src = 8'h00;
	logic [15:0] wdat = 16'h0000, rd;
	logic [2:0] pwr = 3'h0, current_osc_select = 3'h0, curo = 3'h5;
	logic [1:0] borc = 2'h3;
	logic [5:0] cfg = 6'h04;
	wire logic ack, msr, run, mon, fps, wde, boe, tick, lock, valid;
	wire logic [2:0] osel;
	wire logic [31:0] rdat;
	int err_total = 0, check_count = 0, n, k;
	int bp[8] = '{0, 7, 6, 4, 1, 15, 14, 9};
	always #5 clk = !clk;
	src_osc_model u_osc (.clk_i(clk), .rst_i(rst), .clk_ok_i(clk_ok), .tick_o(tick),
		.lock_o(lock), .valid_o(valid));
	src_reset_ctrl #(.POWERUP_DELAY_CYC(50)) u_dut (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
		.wb_dat_i({16'h0000, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack), .por_i(src[0]),
		.master_clear_pin_i(src[1]), .reset_instr_i(src[2]), .watchdog_timeout_i(src[3]),
		.brownout_i(src[4]), .trap_conflict_i(src[5]), .illegal_op_i(src[6]),
		.config_mismatch_i(src[7]), .sleep_instr_i(pwr[0]), .idle_instr_i(pwr[1]),
		.in_sleep_i(pwr[2]), .brownout_config_i(borc), .watchdog_fuse_i(cfg[0]),
		.config_osc_select_i(current_osc_select), .clk_switch_en_i(cfg[1]), .powerup_timer_en_i(cfg[2]),
		.two_speed_en_i(cfg[3]), .clock_fail_monitor_en_i(cfg[4]),
		.primary_is_crystal_i(cfg[5]), .osc_tick_i(tick), .pll_lock_i(lock),
		.clock_valid_i(valid), .current_osc_select_i(curo), .master_system_reset_o(msr),
		.code_run_o(run), .osc_select_o(osel), .clock_fail_monitor_run_o(mon),
		.flash_power_in_sleep_o(fps), .watchdog_enable_o(wde), .brownout_enable_o(boe));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// single classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		k = 0;
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
		if (k >= 50) begin
			err_total++;
			$display("BAD %0t bus timeout", $time);
		end
		rd = rdat[15:0];
		cyc <= 0;
		we <= 0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 16'h0000);
		`CHK(rd, e)
	endtask
	task automatic rel;
		n = 0;
		do @(posedge clk); while (msr !== 1'b0 && ++n < 3000);
		if (n >= 3000) begin
			err_total++;
			$display("BAD %0t release timeout", $time);
		end
	endtask
	task automatic hit(input int i);
		@(posedge clk) src[i] <= 1;
		repeat (2) @(posedge clk);
		src[i] <= 0;
		rel();
	endtask
	task automatic pw(input int i);
		@(posedge clk) pwr[i] <= 1;
		@(posedge clk) pwr[i] <= 0;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		rel();
		`CHK(n >= 250 && n <= 260, 1'b1)
		rchk(8'h00, 16'h0003);
		rchk(8'h10, 16'h0000);
		`CHK(run, 1'b1)
		$display("done: power-on");
		wb(1'b1, 8'h00, 16'h0000);
		wb(1'b1, 8'h08, 16'hA5A5);
		wb(1'b1, 8'h0C, 16'h5A5A);
		for (int i = 1; i < 8; i++) begin
			hit(i);
			`CHK(n > 40, i == 4)
			rchk(8'h00, 16'h0001 << bp[i]);
			wb(1'b1, 8'h00, 16'h0000);
		end
		rchk(8'h08, 16'hA5A5);
		rchk(8'h0C, 16'h5A5A);
		hit(3);
		pw(0);
		rchk(8'h00, 16'h0008);
		pw(1);
		rchk(8'h00, 16'h000C);
		wb(1'b1, 8'h00, 16'hFFFF);
		`CHK(msr, 1'b0)
		rchk(8'h00, 16'hC3FF);
		`CHK(fps, 1'b1)
		wb(1'b1, 8'h00, 16'h0000);
		@(posedge clk);
		`CHK(wde, 1'b0)
		cfg[0] <= 1;
		repeat (3) @(posedge clk);
		`CHK(wde, 1'b1)
		borc <= 2'h0;
		hit(4);
		`CHK(n == 0, 1'b1)
		rchk(8'h00, 16'h0000);
		borc <= 2'h2;
		pwr[2] <= 1;
		hit(4);
		`CHK(n == 0, 1'b1)
		rchk(8'h00, 16'h0000);
		pwr[2] <= 0;
		hit(4);
		`CHK(n > 40, 1'b1)
		rchk(8'h00, 16'h0002);
		$display("done: flags");
		cfg <= 6'h06;
		hit(1);
		`CHK(osel, 3'h5)
		hit(0);
		`CHK(osel, 3'h0)
		rchk(8'h08, 16'h0000);
		rchk(8'h0C, 16'h0000);
		cfg[1] <= 0;
		current_osc_select <= 3'h1;
		hit(1);
		`CHK(osel, 3'h1)
		cfg <= 6'h16;
		clk_ok <= 0;
		hit(1);
		repeat (4) @(posedge clk);
		`CHK(mon, 1'b1)
		`CHK(osel, 3'h0)
		clk_ok <= 1;
		$display("done: clock select");
		cfg <= 6'h24;
		current_osc_select <= 3'h2;
		hit(0);
		do @(posedge clk); while (run !== 1'b1 && ++n < 3000);
		`CHK(n >= 2040 && n <= 2070, 1'b1)
		cfg[3] <= 1;
		hit(0);
		`CHK(osel, 3'h0)
		cfg[2] <= 0;
		hit(0);
		`CHK(n >= 200 && n <= 210, 1'b1)
		borc <= 2'h1;
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		rchk(8'h00, 16'h2003);
		`CHK(boe, 1'b1)
		wb(1'b1, 8'h00, 16'h0000);
		@(posedge clk);
		`CHK(boe, 1'b0)
		$display("done: start-up");
		report_and_stop();
	end
	initial begin
		#500000;
		err_total++;
		report_and_stop();
	end
endmodule // src_reset_ctrl_bench
`default_nettype wire
